// ==== rtl/dbs_controller.sv ====
/*
 * Controller end: divides clk into the link clock, waits out the lock count,
 * then runs single two-word read or write bursts from a user request port.
 * Assumes the memory samples pins near the link clock edges.
 */
`timescale 1ns/10ps
module dbs_controller
(
    // system
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    // user request
    input  wire logic                       reqValid,
    input  wire logic                       reqRead,
    input  wire logic [dbs_pkg::ADDR_W-1:0] reqAddr,
    input  wire logic [dbs_pkg::BYTES-1:0]  reqByteEn,
    input  wire logic [dbs_pkg::DATA_W-1:0] reqData0,
    input  wire logic [dbs_pkg::DATA_W-1:0] reqData1,
    output logic                            reqReady,
    // read answer
    output logic                            rdValid,
    output logic [dbs_pkg::DATA_W-1:0]      rdData0,
    output logic [dbs_pkg::DATA_W-1:0]      rdData1,
    // link
    dbs_link_if.controller                  link
);
    typedef enum logic [5:0]
    {
        ST_LOCK  = 6'h01,
        ST_IDLE  = 6'h02,
        ST_CMD   = 6'h04,
        ST_DATA  = 6'h08,
        ST_WAIT  = 6'h10,
        ST_GAP   = 6'h20
    } dbs_state_e;

    // ************************************************************
    // link clock divider; launch and midHigh mark the low and high phase midpoints
    // ************************************************************
    logic [dbs_pkg::DIV_W-1:0] divCnt;
    logic                      kTick;

    assign kTick = divCnt == dbs_pkg::DIV_W'(dbs_pkg::HALF_DIV - 1);

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            divCnt    <= '0;
            link.kClk <= 1'b0;
        end
        else
        begin
            divCnt <= kTick ? '0 : divCnt + 1'b1;
            if (kTick)
                link.kClk <= !link.kClk;
        end
    end

    // mid-low: pins launched here sit stable around the next rising edge
    logic launch;
    logic midHigh;
    assign launch  = !link.kClk && divCnt == dbs_pkg::DIV_W'(dbs_pkg::HALF_DIV / 2); // RULE1
    assign midHigh = link.kClk && divCnt == dbs_pkg::DIV_W'(dbs_pkg::HALF_DIV / 2);

    // ************************************************************
    // sequencer
    // ************************************************************
    dbs_state_e                 state;
    logic [dbs_pkg::LOCK_W-1:0] lockCnt;
    logic [2:0]                 waitCnt;
    logic                       isRead;
    logic [dbs_pkg::DATA_W-1:0] wd1;
    logic [1:0]                 echoSync;
    logic                       echoPrev;

    always_ff @(posedge clk)
        echoSync <= {echoSync[0], link.echo_clk_true};

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state   <= ST_LOCK;
            lockCnt <= '0;
            waitCnt <= 3'h0;
            isRead  <= 1'b0;
            wd1     <= '0;
            reqReady <= 1'b0;
            rdValid <= 1'b0;
            rdData0 <= '0;
            rdData1 <= '0;
            echoPrev <= 1'b0;
            link.outClkTiedHigh       <= 1'b1; // RULE5
            link.align_loop_disable_n <= !dbs_pkg::LINK_SLOW; // RULE4
            link.load_strobe_n        <= 1'b1;
            link.readNotWrite         <= 1'b1;
            link.addr                 <= '0;
            link.byte_write_strobe_n  <= '1;
            link.ctlDataOut           <= '0;
            link.ctlDataOe            <= 1'b0;
        end
        else
        begin
            rdValid  <= 1'b0;
            echoPrev <= echoSync[1];
            case (state)
                ST_LOCK:
                    if (launch)
                    begin
                        lockCnt <= lockCnt + 1'b1; // RULE3
                        if (lockCnt == dbs_pkg::LOCK_W'(dbs_pkg::LOCK_CYCLES))
                        begin
                            state    <= ST_IDLE;
                            reqReady <= 1'b1;
                        end
                    end
                ST_IDLE:
                    if (reqValid)
                    begin
                        reqReady <= 1'b0;
                        isRead   <= reqRead;
                        wd1      <= reqData1;
                        link.readNotWrite <= reqRead; // RULE12
                        link.addr         <= reqAddr;
                        link.ctlDataOut   <= reqData0;
                        link.byte_write_strobe_n <= reqRead ? '1 : ~reqByteEn; // RULE6
                        state <= ST_CMD;
                    end
                ST_CMD:
                    if (launch)
                    begin
                        link.load_strobe_n <= 1'b0; // RULE13
                        state <= ST_DATA;
                    end
                ST_DATA:
                    // first word sits around the next falling edge, second around the rising
                    if (midHigh)
                    begin
                        link.load_strobe_n <= 1'b1;
                        link.ctlDataOe     <= !isRead;
                    end
                    else if (launch)
                    begin
                        link.ctlDataOut <= wd1;
                        waitCnt <= 3'h0;
                        state   <= isRead ? ST_WAIT : ST_GAP;
                    end
                ST_WAIT:
                    // sample read words on link edges a quarter period late
                    if (midHigh || launch)
                    begin
                        waitCnt <= waitCnt + 1'b1;
                        if (waitCnt == 3'h1)
                            rdData0 <= link.dataBus; // RULE7
                        if (waitCnt == 3'h2)
                        begin
                            rdData1 <= link.dataBus; // RULE8
                            rdValid <= 1'b1;
                            waitCnt <= 3'h0;
                            state   <= ST_GAP;
                        end
                    end
                ST_GAP:
                    // extra idle cycles keep the bus turnaround clean
                    if (launch)
                    begin
                        link.ctlDataOe <= 1'b0;
                        link.byte_write_strobe_n <= '1;
                        waitCnt <= waitCnt + 1'b1;
                        if (waitCnt == 3'h1) // RULE11
                        begin
                            state    <= ST_IDLE;
                            reqReady <= 1'b1;
                        end
                    end
                default:
                    state <= ST_LOCK;
            endcase
        end
    end
endmodule

// ==== rtl/dbs_link_if.sv ====
/*
 * Pins between controller and memory. The common data bus is resolved here
 * from the two output enables; a clash reads as unknown, and an idle bus
 * shows the inverse of the last read word so a late sample cannot pass.
 */
`timescale 1ns/10ps
interface dbs_link_if;
    logic                        kClk;
    logic                        outClkTiedHigh;
    logic                        load_strobe_n;
    logic                        readNotWrite;
    logic [dbs_pkg::ADDR_W-1:0]  addr;
    logic [dbs_pkg::BYTES-1:0]   byte_write_strobe_n;
    logic                        align_loop_disable_n;
    logic [dbs_pkg::DATA_W-1:0]  ctlDataOut;
    logic                        ctlDataOe;
    logic [dbs_pkg::DATA_W-1:0]  memDataOut;
    logic                        memDataOe;
    logic                        echo_clk_true;
    logic                        echo_clk_comp;
    logic [dbs_pkg::DATA_W-1:0]  dataBus;

    assign dataBus = (ctlDataOe && memDataOe) ? 'x :
                     ctlDataOe ? ctlDataOut : memDataOe ? memDataOut : ~memDataOut;

    modport memory
    (
        input  kClk, outClkTiedHigh, load_strobe_n, readNotWrite, addr,
               byte_write_strobe_n, align_loop_disable_n, dataBus,
        output memDataOut, memDataOe, echo_clk_true, echo_clk_comp
    );
    modport controller
    (
        output kClk, outClkTiedHigh, load_strobe_n, readNotWrite, addr,
               byte_write_strobe_n, align_loop_disable_n, ctlDataOut, ctlDataOe,
        input  dataBus, echo_clk_true, echo_clk_comp
    );
endinterface

// ==== rtl/dbs_memory.sv ====
/*
 * Memory end: samples the link clock with clk, registers commands on link rising
 * edges, takes data on rising and falling edges (both clock phases), returns
 * read words and echo clocks.
 * Assumes the controller changes pins a quarter link period away from edges.
 */
`timescale 1ns/10ps
module dbs_memory
(
    // system
    input  wire logic   clk,
    input  wire logic   sys_rst,
    // link
    dbs_link_if.memory  link,
    // status
    output logic        locked
);
    // ************************************************************
    // synchronisers and edges
    // ************************************************************
    logic [1:0]                 kSync;
    logic [1:0]                 tiedSync;
    logic [1:0]                 doffSync;
    logic                       kPrev;
    logic                       kRise;
    logic                       kFall;
    logic                       loadS;
    logic                       rnwS;
    logic [dbs_pkg::ADDR_W-1:0] addrS;
    logic [dbs_pkg::BYTES-1:0]  bwS;
    logic [dbs_pkg::DATA_W-1:0] dataS;
    logic [dbs_pkg::BYTES-1:0]  bwS1;
    logic [dbs_pkg::DATA_W-1:0] dataS1;
    logic                       loadS1;
    logic                       rnwS1;
    logic [dbs_pkg::ADDR_W-1:0] addrS1;

    always_ff @(posedge clk)
    begin
        kSync    <= {kSync[0], link.kClk};
        tiedSync <= {tiedSync[0], link.outClkTiedHigh};
        doffSync <= {doffSync[0], link.align_loop_disable_n};
        loadS1   <= link.load_strobe_n;
        rnwS1    <= link.readNotWrite;
        addrS1   <= link.addr;
        bwS1     <= link.byte_write_strobe_n;
        dataS1   <= link.dataBus;
        loadS    <= loadS1;
        rnwS     <= rnwS1;
        addrS    <= addrS1;
        bwS      <= bwS1;
        dataS    <= dataS1;
        kPrev    <= kSync[1];
    end

    assign kRise = kSync[1] && !kPrev;
    assign kFall = !kSync[1] && kPrev;

    // ************************************************************
    // alignment lock
    // ************************************************************
    logic [dbs_pkg::LOCK_W-1:0] lockCnt;

    // bypassed loop counts as locked at once; no timing alignment modelled
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            lockCnt <= '0;
        else if (!doffSync[1])
            lockCnt <= dbs_pkg::LOCK_W'(dbs_pkg::LOCK_CYCLES); // RULE4
        else if (kRise && lockCnt != dbs_pkg::LOCK_W'(dbs_pkg::LOCK_CYCLES))
            lockCnt <= lockCnt + 1'b1; // RULE2
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            locked <= 1'b0;
        else
            locked <= (lockCnt == dbs_pkg::LOCK_W'(dbs_pkg::LOCK_CYCLES)); // RULE2
    end

    // ************************************************************
    // command capture and write path
    // ************************************************************
    logic [dbs_pkg::DATA_W-1:0] mem [dbs_pkg::DEPTH];
    logic                       wrPend;
    logic                       wrSecond;
    logic [dbs_pkg::ADDR_W-1:0] wrAddr;
    logic [dbs_pkg::ADDR_W-1:0] lastWrAddr;
    logic [dbs_pkg::DATA_W-1:0] fwd0;
    logic [dbs_pkg::DATA_W-1:0] fwd1;
    logic                       lastWasWrite;
    logic                       rdPend;
    logic [dbs_pkg::ADDR_W-1:0] rdAddr;
    logic                       rdFwd;
    logic [dbs_pkg::DATA_W-1:0] maskedWord;

    // write word merges only enabled byte lanes
    always_comb
    begin
        maskedWord = mem[wrAddr];
        for (int b = 0; b < dbs_pkg::BYTES; b++)
            if (!bwS[b])
                maskedWord[b*dbs_pkg::BYTE_W +: dbs_pkg::BYTE_W] =
                    dataS[b*dbs_pkg::BYTE_W +: dbs_pkg::BYTE_W]; // RULE6
    end

    // write data lands on the falling edge after the command and the next rising edge
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wrPend   <= 1'b0;
            wrSecond <= 1'b0;
            rdPend   <= 1'b0;
            lastWasWrite <= 1'b0;
            rdFwd    <= 1'b0;
            wrAddr   <= '0;
            lastWrAddr <= '0;
            rdAddr   <= '0;
            fwd0     <= '0;
            fwd1     <= '0;
        end
        else
        begin
            if (kFall && wrPend)
            begin
                mem[wrAddr] <= maskedWord; // RULE1
                fwd0        <= maskedWord; // RULE10
                wrAddr      <= wrAddr + 1'b1; // RULE8
                wrPend      <= 1'b0;
                wrSecond    <= 1'b1;
            end
            if (kRise)
            begin
                if (wrSecond)
                begin
                    mem[wrAddr] <= maskedWord; // RULE6
                    fwd1        <= maskedWord; // RULE10
                    wrSecond    <= 1'b0;
                end
                rdPend <= 1'b0;
                if (!loadS) // RULE13
                begin
                    if (rnwS) // RULE12
                    begin
                        rdPend <= 1'b1;
                        rdAddr <= addrS;
                        rdFwd  <= lastWasWrite && addrS == lastWrAddr; // RULE10
                        lastWasWrite <= 1'b0;
                    end
                    else
                    begin
                        wrPend     <= 1'b1;
                        wrAddr     <= addrS;
                        lastWrAddr <= addrS;
                        lastWasWrite <= 1'b1;
                    end
                end
            end
        end
    end

    // ************************************************************
    // read return: data on the falling edge one cycle after the
    // command edge (1.5 cycles), second word on the next rising edge,
    // bus released on the falling edge after that (2.5 cycles)
    // ************************************************************
    logic [1:0]                 rdStage;
    logic [dbs_pkg::ADDR_W-1:0] outAddr;
    logic                       outFwd;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rdStage <= 2'h0;
            outAddr <= '0;
            outFwd  <= 1'b0;
            link.memDataOe  <= 1'b0;
            link.memDataOut <= '0;
        end
        else
        begin
            if (kRise)
            begin
                if (rdStage == 2'h2)
                begin
                    link.memDataOut <= outFwd ? fwd1 : mem[outAddr + 1'b1]; // RULE8
                    rdStage <= 2'h3;
                end
                if (rdPend) // RULE7
                begin
                    rdStage <= 2'h1;
                    outAddr <= rdAddr;
                    outFwd  <= rdFwd;
                end
            end
            if (kFall && rdStage == 2'h1)
            begin
                link.memDataOe  <= 1'b1;
                link.memDataOut <= outFwd ? fwd0 : mem[outAddr]; // RULE10
                rdStage <= 2'h2;
            end
            else if (kFall && rdStage == 2'h3)
            begin
                link.memDataOe <= 1'b0; // RULE9
                rdStage <= 2'h0;
            end
        end
    end

    // echo clocks follow the link clock; with output clocks tied high they
    // are timed from the input pair, the only timing source here anyway
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            link.echo_clk_true <= 1'b0;
            link.echo_clk_comp <= 1'b1;
        end
        else
        begin
            link.echo_clk_true <= tiedSync[1] ? kSync[1] : kSync[1]; // RULE5
            link.echo_clk_comp <= !kSync[1];
        end
    end
endmodule

// ==== rtl/dbs_pkg.sv ====
/*
 * Shared constants for the two-word burst double-data-rate SRAM port model:
 * widths, lock count and the link clock divider.
 * Assumes both ends share clk and sys_rst; the link clock is sampled as data.
 */
// How it works
// [RULE1] inputs sampled only on their latching edges
// [RULE2] alignment loop locks after 1024 stable cycles
// [RULE3] controller issues nothing while lock counts
// [RULE4] below 180MHz controller drives loop disable low
// [RULE5] output clocks tied high: time from input
// [RULE6] byte strobes captured with their data word
// [RULE7] read data appears 1.5 cycles after command
// [RULE8] two words: address, then burst-counter next
// [RULE9] bus released latency plus burst times half
// [RULE10] read after write to same address forwards
// [RULE11] controller may add idle between read/write
// [RULE12] load strobe, read/write select, byte strobes
// [RULE13] load low registers command, high is idle
package dbs_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 36;
    localparam int BYTES = 4;
    localparam int BYTE_W = DATA_W / BYTES;
    localparam int DEPTH = 1 << ADDR_W;
    localparam int LOCK_CYCLES = 1024;
    localparam int LOCK_W = 11;
    // link clock half period in clk cycles: 8, from a 160 ns period at 100 MHz
    localparam int LINK_PERIOD_NS = 160;
    localparam int CLK_PERIOD_NS = 10;
    localparam int HALF_DIV = LINK_PERIOD_NS / CLK_PERIOD_NS / 2;
    localparam int DIV_W = 4;
    localparam int SLOW_MHZ = 180;
    // link clock rate is 1000/160 MHz, far below the alignment threshold
    localparam bit LINK_SLOW = (1000 / LINK_PERIOD_NS) < SLOW_MHZ;
endpackage

// ==== tb/dbs_link_sva.sv ====
/*
 * Checker on the link pins between the controller and memory ends.
 * Assumes one clk domain with sys_rst synchronous high; instantiated beside the link.
 */
`timescale 1ns/10ps
module dbs_link_sva
(
    // system
    input wire logic                       clk,
    input wire logic                       sys_rst,
    // link
    input wire logic                       kClk,
    input wire logic                       outClkTiedHigh,
    input wire logic                       load_strobe_n,
    input wire logic                       readNotWrite,
    input wire logic [dbs_pkg::ADDR_W-1:0] addr,
    input wire logic [dbs_pkg::BYTES-1:0]  byte_write_strobe_n,
    input wire logic                       align_loop_disable_n,
    input wire logic [dbs_pkg::DATA_W-1:0] ctlDataOut,
    input wire logic                       ctlDataOe,
    input wire logic                       memDataOe,
    input wire logic                       echo_clk_true,
    input wire logic                       echo_clk_comp
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic        kPrev;
    logic [10:0] kRises;
    logic [5:0]  oeLen;
    wire         cmdRise = kClk && !kPrev && !load_strobe_n;

    // ************************************************************
    // helper counters
    // ************************************************************
    always_ff @(posedge clk)
        kPrev <= sys_rst ? 1'b0 : kClk;

    // saturates so a long run never wraps back into the lock window
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            kRises <= '0;
        else if (kClk && !kPrev && kRises != 11'h7ff)
            kRises <= kRises + 11'h001;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst || !memDataOe)
            oeLen <= '0;
        else if (oeLen != 6'h3f)
            oeLen <= oeLen + 6'h01;
    end

    // ************************************************************
    // link properties
    // ************************************************************
    lock_idle_a: assert property (kRises < 11'h400 |-> load_strobe_n)
        else $error("command issued before lock count elapsed");
    loop_off_a: assert property (!align_loop_disable_n)
        else $error("alignment loop not disabled on slow link");
    tied_high_a: assert property (outClkTiedHigh)
        else $error("output clock pair not tied high");
    echo_true_a: assert property ($rose(kClk) |-> ##[1:4] $rose(echo_clk_true))
        else $error("true echo clock does not follow link clock");
    echo_comp_a: assert property ($fell(kClk) |-> ##[1:4] $rose(echo_clk_comp))
        else $error("complement echo clock does not follow link clock");
    ctl_stable_a: assert property ($rose(kClk) |-> $stable(load_strobe_n)
        && $stable(readNotWrite) && $stable(addr))
        else $error("control or address moves at latching edge");
    wdata_stable_a: assert property ($changed(kClk) && ctlDataOe |-> $stable(ctlDataOut)
        && $stable(byte_write_strobe_n))
        else $error("write data or byte strobes move at latching edge");
    read_latency_a: assert property (cmdRise && readNotWrite |-> !memDataOe [*8] ##[13:23] $rose(memDataOe))
        else $error("read data not driven one and a half cycles after command");
    bus_release_a: assert property ($fell(memDataOe) |-> oeLen >= 6'h0e && oeLen <= 6'h12)
        else $error("read bus not released after two half cycles");
    write_drive_a: assert property (cmdRise && !readNotWrite |-> !memDataOe throughout (##[1:12] ctlDataOe))
        else $error("write command without controller driving data");
    no_clash_a: assert property (!(ctlDataOe && memDataOe))
        else $error("both ends drive the data bus");
endmodule

// ==== tb/tb_ddr_burst2_sram_port.sv ====
/*
 * Self-checking bench: controller and memory joined by the link, user side
 * driven with writes and reads, read words compared with a word model.
 * Assumes the ends leave the lock phase on their own after reset.
 */
`timescale 1ns/10ps
module tb_ddr_burst2_sram_port;
    typedef logic [dbs_pkg::DATA_W-1:0] dbs_word_t;

    logic                        clk;
    logic                        sys_rst;
    logic                        reqValid;
    logic                        reqRead;
    logic [dbs_pkg::ADDR_W-1:0]  reqAddr;
    logic [dbs_pkg::BYTES-1:0]   reqByteEn;
    dbs_word_t                   reqData0;
    dbs_word_t                   reqData1;
    logic                        reqReady;
    logic                        rdValid;
    dbs_word_t                   rdData0;
    dbs_word_t                   rdData1;
    logic                        locked;
    int                          miscompares;
    int                          n_checks;
    int                          cycles;
    int                          kRiseCnt;
    logic                        kPrev;
    dbs_word_t                   model [int];

    dbs_link_if link ();
    dbs_memory dbs_memory_inst (.clk(clk), .sys_rst(sys_rst), .link(link.memory), .locked(locked));
    dbs_controller dbs_controller_inst
    (
        .clk(clk), .sys_rst(sys_rst), .reqValid(reqValid), .reqRead(reqRead), .reqAddr(reqAddr),
        .reqByteEn(reqByteEn), .reqData0(reqData0), .reqData1(reqData1), .reqReady(reqReady),
        .rdValid(rdValid), .rdData0(rdData0), .rdData1(rdData1), .link(link.controller)
    );
    dbs_link_sva dbs_link_sva_inst
    (
        .clk(clk), .sys_rst(sys_rst), .kClk(link.kClk), .outClkTiedHigh(link.outClkTiedHigh),
        .load_strobe_n(link.load_strobe_n), .readNotWrite(link.readNotWrite), .addr(link.addr),
        .byte_write_strobe_n(link.byte_write_strobe_n), .align_loop_disable_n(link.align_loop_disable_n),
        .ctlDataOut(link.ctlDataOut), .ctlDataOe(link.ctlDataOe), .memDataOe(link.memDataOe),
        .echo_clk_true(link.echo_clk_true), .echo_clk_comp(link.echo_clk_comp)
    );

    // ************************************************************
    // clock, watchdog and shared tasks
    // ************************************************************
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // lock phase is about 16400 cycles, traffic well under 20000 more
    always @(posedge clk)
    begin
        cycles++;
        kPrev <= link.kClk;
        if (!sys_rst && link.kClk && !kPrev)
            kRiseCnt++;
        if (cycles == 60000)
        begin
            miscompares++;
            $display("mismatch run length expected %0d seen %0d", 59999, cycles);
            results();
        end
    end

    task automatic results();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string what, input dbs_word_t exp, input dbs_word_t got);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_for(ref logic flag, input int limit);
        int n;
        n = 0;
        while (flag !== 1'b1 && n < limit)
        begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    task automatic request(input logic rd, input logic [7:0] a, input logic [3:0] be,
                           input dbs_word_t d0, input dbs_word_t d1);
        wait_for(reqReady, 400);
        reqValid = 1'b1;
        reqRead = rd;
        reqAddr = a;
        reqByteEn = be;
        reqData0 = d0;
        reqData1 = d1;
        @(posedge clk);
        #1;
        reqValid = 1'b0;
    endtask

    task automatic do_write(input logic [7:0] a, input logic [3:0] be, input dbs_word_t d0, input dbs_word_t d1);
        int k;
        request(1'b0, a, be, d0, d1);
        for (int w = 0; w < 2; w++)
        begin
            k = int'(8'(a + 8'(w)));
            if (!model.exists(k))
                model[k] = '0;
            for (int l = 0; l < dbs_pkg::BYTES; l++)
                if (be[l])
                    model[k][l*dbs_pkg::BYTE_W +: dbs_pkg::BYTE_W] =
                        dbs_pkg::BYTE_W'((w == 0 ? d0 : d1) >> (l*dbs_pkg::BYTE_W));
        end
    endtask

    task automatic do_read(input logic [7:0] a);
        request(1'b1, a, 4'hf, '0, '0);
        wait_for(rdValid, 200);
        check("rdValid", 1'b1, rdValid);
        check("rdData0", model[int'(a)], rdData0);
        check("rdData1", model[int'(8'(a + 8'h01))], rdData1);
    endtask

    function automatic dbs_word_t rword();
        return dbs_word_t'({$urandom(), $urandom()});
    endfunction

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        sys_rst = 1'b1;
        reqValid = 1'b0;
        reqRead = 1'b0;
        reqAddr = '0;
        reqByteEn = '0;
        reqData0 = '0;
        reqData1 = '0;
        miscompares = 0;
        n_checks = 0;
        cycles = 0;
        kRiseCnt = 0;
        repeat (16) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        void'($urandom(32'hf1d2));
        wait_for(reqReady, 30000);
        check("rises before ready", 1'b1, dbs_word_t'(kRiseCnt >= 1024));
        check("locked", 1'b1, locked);
        for (int a = 0; a < 18; a += 2)
            do_write(8'(a), 4'hf, rword(), rword());
        do_write(8'hff, 4'hf, rword(), rword());
        do_read(8'hff);
        do_read(8'hff);
        // one lane at a time, then none, with a read between so no forwarding
        for (int l = 0; l < 5; l++)
        begin
            do_write(8'h05, (l == 4) ? 4'h0 : 4'(1 << l), rword(), rword());
            do_read(8'h00);
            do_read(8'h05);
        end
        for (int i = 0; i < 30; i++)
        begin
            if ($urandom_range(0, 1) == 1)
                do_read(8'($urandom_range(0, 16)));
            else
                do_write(8'($urandom_range(0, 16)), 4'($urandom()), rword(), rword());
        end
        results();
    end
endmodule
